// ==== hw/tcs_func_select.sv ====
// Channel 2 function select: four control registers, eight general registers,
// compare outputs, capture inputs and event interrupt, behind an AHB-Lite slave.
// Assumes a single-slave bus, cnt_value and standby inputs on hclk, pins asynchronous.
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.

`timescale 1ns/1ps

module tcs_func_select
	import tcs_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic [tcs_pkg::GR_W-1:0] cnt_value,
	input  wire logic                  hw_standby,
	input  wire logic                  sw_standby,
	input  wire logic [tcs_pkg::N_GR-1:0] ch2_capture_compare_pin_in,
	output logic      [tcs_pkg::N_GR-1:0] ch2_capture_compare_pin_out,
	output logic      [tcs_pkg::N_GR-1:0] ch2_capture_compare_pin_oe_n,
	output logic                       irq
);

	import tcs_pkg::*;

	// ==========================================================
	// State and next state
	tcs_state_t st_ff;
	tcs_state_t nxt_st;

	logic              acc;
	logic              standby;
	logic [N_GR-1:0]   cap_hit;
	logic [N_GR-1:0]   match;
	logic [N_GR-1:0]   cap_armed;
	logic [N_GR-1:0]   rise;
	logic [N_GR-1:0]   fall;
	logic [EVT_W-1:0]  w1c;
	logic [N_GR-1:0]   gr_wr;
	logic [31:0]       rd_val;

	assign acc     = hsel && htrans[1] && hready;
	assign standby = hw_standby || sw_standby;

	// ==========================================================
	// Next-state logic
	always_comb begin
		nxt_st    = st_ff;
		w1c       = '0;
		gr_wr     = '0;
		rd_val    = 32'h0000_0000;
		cap_hit   = '0;
		match     = '0;
		cap_armed = '0;
		rise      = '0;
		fall      = '0;

		nxt_st.sync1    = ch2_capture_compare_pin_in;
		nxt_st.sync2    = st_ff.sync1;
		nxt_st.prev     = st_ff.sync2;
		nxt_st.cnt_prev = cnt_value;
		nxt_st.ready    = 1'b1;
		nxt_st.resp     = 1'b0;

		// Data phase of a write
		if (st_ff.dp_wr) begin
			if (st_ff.dp_addr == OFF_FSEL_AB) begin
				nxt_st.func[1] = hwdata[FLD_HI_LSB +: 3];
				nxt_st.func[0] = hwdata[FLD_LO_LSB +: 3];
			end else if (st_ff.dp_addr == OFF_FSEL_CD) begin
				nxt_st.func[3] = hwdata[FLD_HI_LSB +: 3];
				nxt_st.func[2] = hwdata[FLD_LO_LSB +: 3];
			end else if (st_ff.dp_addr == OFF_FSEL_EF) begin
				nxt_st.func[5] = hwdata[FLD_HI_LSB +: 3];
				nxt_st.func[4] = hwdata[FLD_LO_LSB +: 3];
			end else if (st_ff.dp_addr == OFF_FSEL_GH) begin
				nxt_st.func[7] = hwdata[FLD_HI_LSB +: 3];
				nxt_st.func[6] = hwdata[FLD_LO_LSB +: 3];
			end else if (st_ff.dp_addr[7:5] == GR_PAGE && st_ff.dp_addr[1:0] == 2'b00) begin
				gr_wr[st_ff.dp_addr[4:2]] = 1'b1;
			end else if (st_ff.dp_addr == OFF_STATUS) begin
				w1c = hwdata[EVT_W-1:0];
			end else if (st_ff.dp_addr == OFF_MASK) begin
				nxt_st.mask = hwdata[EVT_W-1:0];
			end
		end

		// Per general register behaviour
		for (int i = 0; i < N_GR; i++) begin
			rise[i]      = st_ff.sync2[i] && !st_ff.prev[i];
			fall[i]      = !st_ff.sync2[i] && st_ff.prev[i];
			cap_armed[i] = st_ff.func[i][FLD_ROLE] && (st_ff.func[i][1:0] != TCS_CAP_OFF);
			if (st_ff.func[i][FLD_ROLE]) begin
				case (st_ff.func[i][1:0])
					TCS_CAP_RISE: cap_hit[i] = rise[i];
					TCS_CAP_FALL: cap_hit[i] = fall[i];
					TCS_CAP_BOTH: cap_hit[i] = rise[i] || fall[i];
					default:      cap_hit[i] = 1'b0;
				endcase
				nxt_st.pin_oe_n[i] = 1'b1;
			end else begin
				match[i] = (st_ff.func[i][1:0] != TCS_CMP_OFF) && (cnt_value == st_ff.gr[i])
					&& (cnt_value != st_ff.cnt_prev);
				nxt_st.pin_oe_n[i] = (st_ff.func[i][1:0] == TCS_CMP_OFF);
				if (match[i]) begin
					case (st_ff.func[i][1:0])
						TCS_CMP_LOW:    nxt_st.pin_out[i] = 1'b0;
						TCS_CMP_HIGH:   nxt_st.pin_out[i] = 1'b1;
						TCS_CMP_TOGGLE: nxt_st.pin_out[i] = !st_ff.pin_out[i];
						default:        nxt_st.pin_out[i] = st_ff.pin_out[i];
					endcase
				end
			end
			if (gr_wr[i] && !cap_armed[i]) begin
				nxt_st.gr[i] = hwdata[GR_W-1:0];
			end
			if (cap_hit[i]) begin
				nxt_st.gr[i] = cnt_value;
			end
		end

		// Sticky events, set wins over clear
		nxt_st.status = (st_ff.status & ~w1c)
			| {cap_hit, match};
		nxt_st.irq    = |(nxt_st.status & nxt_st.mask);

		// Standby forces the control registers to zero
		if (standby) begin
			for (int i = 0; i < N_GR; i++) begin
				nxt_st.func[i] = FUNC_RST;
			end
		end

		// Address phase
		nxt_st.dp_wr = acc && hwrite && (haddr[31:8] == 24'h000000);
		if (acc) begin
			nxt_st.dp_addr = haddr[7:0];
		end
		if (acc && !hwrite) begin
			if (haddr[31:8] != 24'h000000) begin
				rd_val = 32'h0000_0000;
			end else if (haddr[7:0] == OFF_FSEL_AB) begin
				rd_val = {24'h000000, 1'b0, st_ff.func[1], 1'b0, st_ff.func[0]};
			end else if (haddr[7:0] == OFF_FSEL_CD) begin
				rd_val = {24'h000000, 1'b0, st_ff.func[3], 1'b0, st_ff.func[2]};
			end else if (haddr[7:0] == OFF_FSEL_EF) begin
				rd_val = {24'h000000, 1'b0, st_ff.func[5], 1'b0, st_ff.func[4]};
			end else if (haddr[7:0] == OFF_FSEL_GH) begin
				rd_val = {24'h000000, 1'b0, st_ff.func[7], 1'b0, st_ff.func[6]};
			end else if (haddr[7:5] == GR_PAGE && haddr[1:0] == 2'b00) begin
				rd_val = {16'h0000, st_ff.gr[haddr[4:2]]};
			end else if (haddr[7:0] == OFF_STATUS) begin
				rd_val = {16'h0000, st_ff.status};
			end else if (haddr[7:0] == OFF_MASK) begin
				rd_val = {16'h0000, st_ff.mask};
			end else begin
				rd_val = 32'h0000_0000;
			end
			nxt_st.rdata = rd_val;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < N_GR; i++) begin
				st_ff.func[i] <= FUNC_RST;
				st_ff.gr[i]   <= GR_RST;
			end
			st_ff.cnt_prev <= GR_RST;
			st_ff.sync1    <= '0;
			st_ff.sync2    <= '0;
			st_ff.prev     <= '0;
			st_ff.pin_out  <= '0;
			st_ff.pin_oe_n <= '1;
			st_ff.status   <= STATUS_RST;
			st_ff.mask     <= MASK_RST;
			st_ff.irq      <= 1'b0;
			st_ff.dp_wr    <= 1'b0;
			st_ff.dp_addr  <= 8'h00;
			st_ff.rdata    <= 32'h0000_0000;
			st_ff.ready    <= 1'b1;
			st_ff.resp     <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs
	assign hrdata                       = st_ff.rdata;
	assign hreadyout                    = st_ff.ready;
	assign hresp                        = st_ff.resp;
	assign ch2_capture_compare_pin_out  = st_ff.pin_out;
	assign ch2_capture_compare_pin_oe_n = st_ff.pin_oe_n;
	assign irq                          = st_ff.irq;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_wr_ab;
		acc && hwrite && haddr == {24'h000000, OFF_FSEL_AB};
	endsequence

	sequence s_rd_cd;
		acc && !hwrite && haddr == {24'h000000, OFF_FSEL_CD};
	endsequence

	sequence s_wr_gr_e;
		acc && hwrite && haddr == {24'h000000, GR_PAGE, 5'h10};
	endsequence

	sequence s_wr_gr_h;
		acc && hwrite && haddr == {24'h000000, GR_PAGE, 5'h1c};
	endsequence

	sequence s_wr_gh;
		acc && hwrite && haddr == {24'h000000, OFF_FSEL_GH};
	endsequence

	sequence s_rd_gh;
		acc && !hwrite && haddr == {24'h000000, OFF_FSEL_GH};
	endsequence

	sequence s_rise_e;
		st_ff.sync2[4] && !st_ff.prev[4];
	endsequence

	sequence s_rise_f;
		st_ff.sync2[5] && !st_ff.prev[5];
	endsequence

	sequence s_fall_f;
		!st_ff.sync2[5] && st_ff.prev[5];
	endsequence

	sequence s_edge_g;
		st_ff.sync2[6] != st_ff.prev[6];
	endsequence

	upper_field_a: assert property (s_wr_ab ##1 !standby |=>
		st_ff.func[1] == $past(hwdata[6:4]))
		else $error("upper field not loaded from bits 6 to 4");

	lower_field_a: assert property (s_wr_ab ##1 !standby |=>
		st_ff.func[0] == $past(hwdata[2:0]))
		else $error("lower field not loaded from bits 2 to 0");

	gh_fields_a: assert property (s_wr_gh ##1 !standby |=>
		st_ff.func[7] == $past(hwdata[6:4]) && st_ff.func[6] == $past(hwdata[2:0]))
		else $error("fields of the last control register not loaded");

	standby_clear_a: assert property (standby |=>
		st_ff.func == '0)
		else $error("control fields not zero after standby");

	reserved_read_a: assert property (s_rd_cd |=>
		hrdata == {24'h000000, 1'b0, $past(st_ff.func[3]), 1'b0, $past(st_ff.func[2])})
		else $error("control readback wrong or reserved bits set");

	reserved_gh_a: assert property (s_rd_gh |=>
		hrdata[31:8] == 24'h000000 && !hrdata[7] && !hrdata[3])
		else $error("reserved bits of the last control register read as one");

	capture_role_a: assert property (st_ff.func[0][2] |=>
		ch2_capture_compare_pin_oe_n[0])
		else $error("pin driven while register is in capture role");

	oe_compare_a: assert property (
		!st_ff.func[0][2] && st_ff.func[0][1:0] != 2'b00 |=> !ch2_capture_compare_pin_oe_n[0])
		else $error("pin not driven while register compares");

	drive_low_a: assert property (match[0] && st_ff.func[0] == 3'b001 |=>
		!ch2_capture_compare_pin_out[0] && !ch2_capture_compare_pin_oe_n[0] && st_ff.status[0])
		else $error("compare match with drive low failed");

	drive_high_a: assert property (match[0] && st_ff.func[0] == 3'b010 |=>
		ch2_capture_compare_pin_out[0] && !ch2_capture_compare_pin_oe_n[0] && st_ff.status[0])
		else $error("compare match with drive high failed");

	toggle_out_a: assert property (match[2] && st_ff.func[2] == 3'b011 |=>
		ch2_capture_compare_pin_out[2] != $past(ch2_capture_compare_pin_out[2]))
		else $error("compare match with toggle failed");

	match_off_a: assert property (st_ff.func[3] == 3'b000 |->
		!match[3] ##1 ch2_capture_compare_pin_oe_n[3])
		else $error("disabled compare matched or drove its pin");

	compare_match_a: assert property (
		st_ff.func[1] == 3'b010 && cnt_value == st_ff.gr[1] && cnt_value != st_ff.cnt_prev
		|=> ch2_capture_compare_pin_out[1] && st_ff.status[1])
		else $error("counter reaching the register did not match");

	no_repeat_a: assert property (cnt_value == st_ff.cnt_prev |-> match == 8'h00)
		else $error("match repeated while the counter held");

	falling_only_a: assert property (s_rise_f ##0 st_ff.func[5] == 3'b110 |=>
		!st_ff.status[13] || $past(st_ff.status[13]))
		else $error("falling edge capture fired on rising edge");

	fall_capture_a: assert property (s_fall_f ##0 st_ff.func[5] == 3'b110 |=>
		st_ff.gr[5] == $past(cnt_value) && st_ff.status[13])
		else $error("falling edge did not capture the counter");

	capture_load_a: assert property (s_rise_e ##0 st_ff.func[4] == 3'b101 |=>
		st_ff.gr[4] == $past(cnt_value) && st_ff.status[12])
		else $error("rising edge did not capture the counter");

	rise_only_a: assert property (
		!st_ff.sync2[4] && st_ff.prev[4] && st_ff.func[4] == 3'b101 |=> $stable(st_ff.gr[4]))
		else $error("rising edge capture fired on falling edge");

	both_edge_a: assert property (s_edge_g ##0 st_ff.func[6] == 3'b111 |=>
		st_ff.gr[6] == $past(cnt_value) && st_ff.status[14])
		else $error("edge on both-edge capture not taken");

	capture_off_a: assert property (
		st_ff.sync2[7] != st_ff.prev[7] && st_ff.func[7] == 3'b100 && !gr_wr[7]
		|=> $stable(st_ff.gr[7]))
		else $error("capture taken although capture is off");

	write_block_a: assert property (s_wr_gr_e ##1 (cap_armed[4] && !cap_hit[4]) |=>
		$stable(st_ff.gr[4]))
		else $error("general register written while capture armed");

	open_write_a: assert property (s_wr_gr_h ##1 st_ff.func[7] == 3'b100 |=>
		st_ff.gr[7] == $past(hwdata[15:0]))
		else $error("write refused while capture is off");

	irq_level_a: assert property (irq == |(st_ff.status & st_ff.mask))
		else $error("interrupt does not follow masked status");

	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered with an error");

endmodule : tcs_func_select

// ==== hw/tcs_pkg.sv ====
// Constants, register map and state layout of the channel 2 function-select block.
// Assumes one 100 MHz bus clock; counter and standby inputs come from the same domain.

package tcs_pkg;

	// ==========================================================
	// Sizes
	localparam int unsigned N_GR  = 8;
	localparam int unsigned GR_W  = 16;
	localparam int unsigned EVT_W = 16;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFF_FSEL_AB = 8'h00;
	localparam logic [7:0] OFF_FSEL_CD = 8'h04;
	localparam logic [7:0] OFF_FSEL_EF = 8'h08;
	localparam logic [7:0] OFF_FSEL_GH = 8'h0c;
	localparam logic [2:0] GR_PAGE     = 3'h1;
	localparam logic [7:0] OFF_STATUS  = 8'h40;
	localparam logic [7:0] OFF_MASK    = 8'h44;

	// ==========================================================
	// Field layout of a function-select register and of the status register
	localparam int unsigned FLD_HI_LSB = 4;
	localparam int unsigned FLD_LO_LSB = 0;
	localparam int unsigned FLD_ROLE   = 2;
	localparam int unsigned CMP_EVT_LSB = 0;
	localparam int unsigned CAP_EVT_LSB = 8;

	// ==========================================================
	// Values after reset
	localparam logic [2:0]       FUNC_RST   = 3'h0;
	localparam logic [GR_W-1:0]  GR_RST     = 16'h0000;
	localparam logic [EVT_W-1:0] STATUS_RST = 16'h0000;
	localparam logic [EVT_W-1:0] MASK_RST   = 16'h0000;

	// ==========================================================
	// Encodings of the lower two field bits
	typedef enum logic [1:0] {
		TCS_CMP_OFF    = 2'b00,
		TCS_CMP_LOW    = 2'b01,
		TCS_CMP_HIGH   = 2'b10,
		TCS_CMP_TOGGLE = 2'b11
	} tcs_cmp_t;

	typedef enum logic [1:0] {
		TCS_CAP_OFF  = 2'b00,
		TCS_CAP_RISE = 2'b01,
		TCS_CAP_FALL = 2'b10,
		TCS_CAP_BOTH = 2'b11
	} tcs_cap_t;

	// ==========================================================
	// Whole state of the block
	typedef struct packed {
		logic [N_GR-1:0][2:0]      func;
		logic [N_GR-1:0][GR_W-1:0] gr;
		logic [GR_W-1:0]           cnt_prev;
		logic [N_GR-1:0]           sync1;
		logic [N_GR-1:0]           sync2;
		logic [N_GR-1:0]           prev;
		logic [N_GR-1:0]           pin_out;
		logic [N_GR-1:0]           pin_oe_n;
		logic [EVT_W-1:0]          status;
		logic [EVT_W-1:0]          mask;
		logic                      irq;
		logic                      dp_wr;
		logic [7:0]                dp_addr;
		logic [31:0]               rdata;
		logic                      ready;
		logic                      resp;
	} tcs_state_t;

endpackage : tcs_pkg

// ==== verification/tcs_pin_model.sv ====
// Far side of the channel pins: an external source of capture levels sharing each wire.
// Assumes the bench sets ext_lvl; a pin the block drives shows the block's level.

`timescale 1ns/1ps

module tcs_pin_model
	import tcs_pkg::*;
(
	input  wire logic [tcs_pkg::N_GR-1:0] ext_lvl,
	input  wire logic [tcs_pkg::N_GR-1:0] pin_out,
	input  wire logic [tcs_pkg::N_GR-1:0] pin_oe_n,
	output logic      [tcs_pkg::N_GR-1:0] pin_in
);
	// ==========================================================
	// Wire level per pin
	always_comb begin
		for (int i = 0; i < N_GR; i++) begin
			pin_in[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
		end
	end
endmodule : tcs_pin_model

// ==== verification/testbench.sv ====
// Self-checking bench for the function-select block over AHB-Lite.
// Assumes zero-wait slave, counter and pins driven by the bench.

`timescale 1ns/1ps

module testbench;
	import tcs_pkg::*;
	logic             hclk, hresetn, hsel, hwrite, hw_standby, sw_standby;
	logic [31:0]      haddr, hwdata, hrdata;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	logic             hreadyout, hresp, irq;
	logic [GR_W-1:0]  cnt_value;
	logic [N_GR-1:0]  ext_lvl, pin_in, pin_out, pin_oe_n;
	int               err_total, n_checks;

	// ==========================================================
	// Clock, design and pins
	always #5 hclk = ~hclk;
	tcs_func_select dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cnt_value(cnt_value),
		.hw_standby(hw_standby), .sw_standby(sw_standby), .ch2_capture_compare_pin_in(pin_in),
		.ch2_capture_compare_pin_out(pin_out), .ch2_capture_compare_pin_oe_n(pin_oe_n),
		.irq(irq));
	tcs_pin_model pins (.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_in(pin_in));

	// ==========================================================
	// Bus tasks and checks
	task results;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				err_total++;
				$display("[ERR] %0t bus timeout", $time);
				results();
			end
			@(posedge hclk);
		end
	endtask : wait_rdy

	task wr(input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= 1'b1;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hwdata <= d;
		wait_rdy();
	endtask : wr

	task rchk(input logic [31:0] a, input logic [31:0] exp, input string what);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= 1'b0;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		wait_rdy();
		chk(hrdata, exp, what);
		chk({31'h0, hresp}, 32'h0, "okay response");
	endtask : rchk

	task step(input int n);
		repeat (n) @(posedge hclk);
	endtask : step

	// ==========================================================
	// Tests
	initial begin
		hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
		hsize = 3'b010; hwdata = 0; cnt_value = 0; hw_standby = 0; sw_standby = 0;
		ext_lvl = 0; err_total = 0; n_checks = 0;
		step(12);
		hresetn <= 1'b1;
		step(1);
		chk({24'h0, pin_oe_n}, 32'hff, "oe reset");
		for (int i = 0; i < 4; i++) begin
			rchk(4 * i, 32'h0, "ctl reset");
			wr(4 * i, 32'hff);
			rchk(4 * i, 32'h77, "ctl fields");
		end
		rchk(32'h50, 32'h0, "unmapped");
		$display("test registers done");
		hw_standby <= 1'b1;
		step(1);
		wr(OFF_FSEL_CD, 32'h11);
		rchk(OFF_FSEL_CD, 32'h0, "hw standby");
		hw_standby <= 1'b0;
		step(1);
		rchk(OFF_FSEL_AB, 32'h0, "after hw standby");
		wr(OFF_FSEL_EF, 32'h22);
		sw_standby <= 1'b1;
		step(1);
		rchk(OFF_FSEL_EF, 32'h0, "sw standby");
		sw_standby <= 1'b0;
		$display("test standby done");
		wr(OFF_FSEL_AB, 32'h22);
		wr(OFF_FSEL_CD, 32'h03);
		for (int i = 0; i < 3; i++) wr(32'h20 + 4 * i, 32'h5);
		cnt_value <= 16'h5;
		step(5);
		chk({pin_oe_n[3:0], 1'b0, pin_out[2:0]}, 8'h87, "first match");
		chk({29'h0, pin_in[2:0]}, 32'h7, "pin level");
		wr(OFF_FSEL_AB, 32'h21);
		cnt_value <= 16'h0;
		step(2);
		cnt_value <= 16'h5;
		step(5);
		chk({29'h0, pin_out[2:0]}, 32'h2, "second match");
		$display("test compare done");
		wr(OFF_FSEL_EF, 32'h65);
		wr(OFF_FSEL_GH, 32'h47);
		wr(32'h30, 32'haaaa);
		rchk(32'h30, 32'h0, "gr blocked");
		wr(32'h3c, 32'h0bad);
		rchk(32'h3c, 32'h0bad, "gr open");
		cnt_value <= 16'h1234;
		ext_lvl <= 8'hf0;
		step(6);
		rchk(32'h34, 32'h0, "fall f on rise");
		rchk(32'h38, 32'h1234, "both g rise");
		cnt_value <= 16'h5678;
		ext_lvl <= 8'h00;
		step(6);
		rchk(32'h30, 32'h1234, "rise e");
		rchk(32'h34, 32'h5678, "fall f");
		rchk(32'h38, 32'h5678, "both g");
		rchk(32'h3c, 32'h0bad, "off h");
		$display("test capture done");
		rchk(OFF_STATUS, 32'h7007, "status");
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(OFF_MASK, 32'h1000);
		step(2);
		chk({31'h0, irq}, 32'h1, "irq on");
		wr(OFF_STATUS, 32'h1000);
		step(2);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rchk(OFF_STATUS, 32'h6007, "status w1c");
		$display("test interrupt done");
		results();
	end
endmodule : testbench
